// ===== capture_model.sv
// capture-side model: latches driven words with the flag, pairs first with the next second
// assumes the port clock and one-cycle words; ignores the bus while released
`timescale 1ns/1ps
module capture_model (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       oe_i,
  input  wire logic       flag_i,
  input  wire logic [7:0] bus_i,
  output logic      [7:0] pair_first_o,
  output logic      [7:0] pair_second_o
);
  logic [7:0] held_reg;
  logic       have_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      have_reg <= 1'b0;
    else if (oe_i && flag_i)
    begin
      held_reg <= bus_i;
      have_reg <= 1'b1;
    end
    else if (oe_i && have_reg)
    begin
      pair_first_o <= held_reg;
      pair_second_o <= bus_i;
      have_reg <= 1'b0;
    end
  end
endmodule

// ===== dual_adc_output_port.sv
// digital side of a dual-channel 8-bit pipelined converter with one multiplexed tri-state result bus
// assumes the system clock is the converter clock at twice its rate: each clk_i edge is one half cycle,
// so rising converter edges are the edges where conv_clk_o goes high
// channel inputs are digital stand-ins for the analog inputs: 11-bit signed, full scale 1024 counts
//
// Overview of operation
// - eight-bit word, msb on top data line
// - indicator high for first, low for second
// - latency five cycles first, five-and-half second
// - pipeline advances every converter half cycle
// - seven stages: resolve, subtract, double residue
// - digital correction makes every code reachable
// - data lines tri-stated when outputs disabled
// - lo,hi 00 off,01 standby,10 idle,11 normal
// - sample rising; first rising, second falling
// - offset binary, 128 means zero input
`timescale 1ns/1ps
module dual_adc_output_port (
  input  wire logic                                      clk_i,
  input  wire logic                                      sys_rst_i,
  input  wire logic                                      pwr_sel_hi_i,
  input  wire logic                                      pwr_sel_lo_i,
  input  wire logic signed [dual_adc_pkg::IN_W-1:0]      first_channel_sample_i,
  input  wire logic signed [dual_adc_pkg::IN_W-1:0]      second_channel_sample_i,
  output logic             [dual_adc_pkg::CODE_W-1:0]    result_bus_o,
  output logic                                           result_bus_oe_o,
  output logic                                           first_channel_flag_o,
  output logic                                           conv_clk_o
);

  dual_adc_pkg::pwr_mode_e mode_next;
  dual_adc_pkg::pwr_mode_e mode_reg;
  logic                    clk_on;
  logic                    conv_run;
  logic                    drive_en;
  logic                    phase_reg;
  logic                    rise_edge;
  logic                    phase_next;
  logic                    cclk_next;
  logic                    flag_next;
  logic                    oe_next;

  logic signed [dual_adc_pkg::IN_W-1:0]   sample_in [dual_adc_pkg::NUM_CHAN];
  dual_adc_pkg::stage_s                   pipe_reg  [dual_adc_pkg::NUM_CHAN][dual_adc_pkg::NUM_STAGES+1];
  logic [dual_adc_pkg::CODE_W-1:0]        code_w    [dual_adc_pkg::NUM_CHAN];
  logic [dual_adc_pkg::CODE_W-1:0]        corr_reg  [dual_adc_pkg::NUM_CHAN];
  logic [dual_adc_pkg::CODE_W-1:0]        first_hold_reg;
  logic [dual_adc_pkg::CODE_W-1:0]        second_hold_reg;
  logic [dual_adc_pkg::CODE_W-1:0]        second_hold2_reg;
  logic [dual_adc_pkg::CODE_W-1:0]        bus_next;

  // one 1.5-bit stage: decide -1/0/+1, subtract reconstructed value, double the error
  // thresholds at a quarter of full scale leave room for comparator offset; the next stage absorbs it
  function automatic dual_adc_pkg::stage_s stage_step(input dual_adc_pkg::stage_s cur, input int unsigned idx);
    dual_adc_pkg::stage_s                       nxt;
    logic signed [dual_adc_pkg::RES_W:0]        twice;
    logic signed [dual_adc_pkg::ACC_W-1:0]      weight;
    nxt    = cur;
    twice  = {cur.residue, 1'b0};
    weight = dual_adc_pkg::ACC_W'(1 << (dual_adc_pkg::NUM_STAGES - idx));
    if (cur.residue > dual_adc_pkg::THRESHOLD)
    begin
      nxt.residue = dual_adc_pkg::RES_W'(twice - dual_adc_pkg::FULL_SCALE);
      nxt.acc     = cur.acc + weight;
    end
    else if (cur.residue < -dual_adc_pkg::THRESHOLD)
    begin
      nxt.residue = dual_adc_pkg::RES_W'(twice + dual_adc_pkg::FULL_SCALE);
      nxt.acc     = cur.acc - weight;
    end
    else
    begin
      nxt.residue = dual_adc_pkg::RES_W'(twice);
    end
    return nxt;
  endfunction

  // power select decode, low bit first; inputs are trusted to be driven by the controller
  // standby and idle differ only in whether the pipeline runs behind the released bus
  always_comb
  begin
    case ({pwr_sel_lo_i, pwr_sel_hi_i})
      2'b00:   mode_next = dual_adc_pkg::PWR_SHUTDOWN;
      2'b01:   mode_next = dual_adc_pkg::PWR_STANDBY;
      2'b10:   mode_next = dual_adc_pkg::PWR_IDLE;
      2'b11:   mode_next = dual_adc_pkg::PWR_NORMAL;
      default: mode_next = dual_adc_pkg::PWR_SHUTDOWN;
    endcase
  end

  assign clk_on    = (mode_reg != dual_adc_pkg::PWR_SHUTDOWN);
  assign conv_run  = (mode_reg == dual_adc_pkg::PWR_IDLE) || (mode_reg == dual_adc_pkg::PWR_NORMAL);
  assign drive_en  = (mode_reg == dual_adc_pkg::PWR_NORMAL);
  // the next edge is a rising converter edge while the converter clock is low
  assign rise_edge = clk_on && !phase_reg;
  // phase restarts low whenever the clock stops, so the first edge after wake is a rising one
  assign phase_next = clk_on ? !phase_reg : 1'b0;

  assign sample_in[0] = first_channel_sample_i;
  assign sample_in[1] = second_channel_sample_i;

  // the select is registered once, so a change reaches the mode one edge later
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_reg  <= dual_adc_pkg::PWR_SHUTDOWN;
      phase_reg <= 1'b0;
    end
    else
    begin
      mode_reg  <= mode_next;
      phase_reg <= phase_next;
    end
  end

  // limitation: wake-up settling is not modelled; the first eleven half cycles after wake are pipeline fill
  genvar c;
  genvar s;
  generate
    for (c = 0; c < dual_adc_pkg::NUM_CHAN; c++)
    begin : g_chan
      // a sample enters with an empty code sum; the stages add their weights from the top bit down
      dual_adc_pkg::stage_s capture_w;
      assign capture_w = '{residue: dual_adc_pkg::RES_W'(sample_in[c]), acc: '0};

      // both channels are captured together, only on rising converter edges
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i || !conv_run)
          pipe_reg[c][0] <= '0;
        else if (rise_edge)
          pipe_reg[c][0] <= capture_w;
      end

      for (s = 1; s <= dual_adc_pkg::NUM_STAGES; s++)
      begin : g_stage
        // every half cycle each stage hands its residue on; samples occupy two slots each
        // only the first slot of each sample is used downstream, the second copy is discarded
        always_ff @(posedge clk_i)
        begin
          if (sys_rst_i || !conv_run)
            pipe_reg[c][s] <= '0;
          else
            pipe_reg[c][s] <= stage_step(pipe_reg[c][s-1], s);
        end
      end

      // final residue sign trims the redundant sum down to the floor; then flip msb for offset binary
      logic signed [dual_adc_pkg::ACC_W-1:0] corr_sum;
      assign corr_sum  = pipe_reg[c][dual_adc_pkg::NUM_STAGES].acc
                       - ((pipe_reg[c][dual_adc_pkg::NUM_STAGES].residue < 0) ? 9'sd1 : 9'sd0);
      assign code_w[c] = {~corr_sum[dual_adc_pkg::CODE_W-1], corr_sum[dual_adc_pkg::CODE_W-2:0]};

      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
          corr_reg[c] <= dual_adc_pkg::RESULT_RESET;
        else
          corr_reg[c] <= code_w[c];
      end
    end
  endgenerate

  // the second channel waits one extra half cycle so it lands on the falling edge
  // both channels share the same correction timing, so the skew is this one register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      first_hold_reg   <= dual_adc_pkg::RESULT_RESET;
      second_hold_reg  <= dual_adc_pkg::RESULT_RESET;
      second_hold2_reg <= dual_adc_pkg::RESULT_RESET;
    end
    else
    begin
      first_hold_reg   <= corr_reg[0];
      second_hold_reg  <= corr_reg[1];
      second_hold2_reg <= second_hold_reg;
    end
  end

  // pin values are chosen here so that the output flops below stay plain copies
  // first-channel word on rising converter edges, second-channel word on falling ones
  assign bus_next  = rise_edge ? first_hold_reg : second_hold2_reg;
  assign flag_next = rise_edge;
  // the live select is ANDed in so that leaving normal releases the bus one edge sooner
  assign oe_next   = (mode_next == dual_adc_pkg::PWR_NORMAL) && drive_en;
  // the converter clock is high in the half cycle after each rising converter edge
  assign cclk_next = clk_on && !phase_reg;

  // word and indicator change on the same edge so that capture logic can latch both together
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      result_bus_o         <= dual_adc_pkg::RESULT_RESET;
      first_channel_flag_o <= 1'b0;
    end
    else
    begin
      result_bus_o         <= bus_next;
      first_channel_flag_o <= flag_next;
    end
  end

  // bus released and converter clock stopped while in reset
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      result_bus_oe_o <= 1'b0;
      conv_clk_o      <= 1'b0;
    end
    else
    begin
      result_bus_oe_o <= oe_next;
      conv_clk_o      <= cclk_next;
    end
  end

endmodule

// ===== dual_adc_pkg.sv
// shared constants and carrier types for the dual-channel pipelined converter output block
// assumes a single 10 MHz system clock; one system cycle is one converter half cycle
package dual_adc_pkg;

  localparam int unsigned IN_W        = 11;
  localparam int unsigned RES_W       = 12;
  localparam int unsigned ACC_W       = 9;
  localparam int unsigned CODE_W      = 8;
  localparam int unsigned NUM_STAGES  = 7;
  localparam int unsigned NUM_CHAN    = 2;

  // residue scale: +/- full scale is +/- 1024 counts, decision thresholds at a quarter of it
  localparam logic signed [RES_W-1:0] FULL_SCALE = 12'sh400;
  localparam logic signed [RES_W-1:0] THRESHOLD  = 12'sh100;

  // latency in converter half cycles (system cycles) from sample edge to bus word
  localparam int unsigned LAT_FIRST_HALF  = 10;
  localparam int unsigned LAT_SECOND_HALF = 11;

  localparam logic [CODE_W-1:0] RESULT_RESET = 8'h00;

  typedef enum logic [3:0] {
    PWR_SHUTDOWN = 4'b0001,
    PWR_STANDBY  = 4'b0010,
    PWR_IDLE     = 4'b0100,
    PWR_NORMAL   = 4'b1000
  } pwr_mode_e;

  typedef struct packed {
    logic signed [RES_W-1:0] residue;
    logic signed [ACC_W-1:0] acc;
  } stage_s;

endpackage

// ===== dual_adc_sva.sv
// checks on the converter port: power select, enable, flag cadence, extreme codes
// assumes binding to the port module on its single clock
`timescale 1ns/1ps
module dual_adc_sva (
  input wire logic                                 clk_i,
  input wire logic                                 sys_rst_i,
  input wire logic                                 pwr_sel_hi_i,
  input wire logic                                 pwr_sel_lo_i,
  input wire logic signed [dual_adc_pkg::IN_W-1:0] first_channel_sample_i,
  input wire logic signed [dual_adc_pkg::IN_W-1:0] second_channel_sample_i,
  input wire logic [dual_adc_pkg::CODE_W-1:0]      result_bus_o,
  input wire logic                                 result_bus_oe_o,
  input wire logic                                 first_channel_flag_o,
  input wire logic                                 conv_clk_o
);
  wire on_w = pwr_sel_hi_i & pwr_sel_lo_i;
  wire off_w = ~pwr_sel_hi_i & ~pwr_sel_lo_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_oe_on; result_bus_oe_o |-> $past(on_w); endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus driven outside normal");
  property p_oe_off; !on_w |=> !result_bus_oe_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus not released");
  property p_flag_alt; first_channel_flag_o |=> !first_channel_flag_o; endproperty
  a_flag_alt: assert property (p_flag_alt) else $error("flag did not alternate");
  property p_flag_clk; first_channel_flag_o |-> conv_clk_o; endproperty
  a_flag_clk: assert property (p_flag_clk) else $error("first word off rising phase");
  property p_sd_stop; off_w[*4] |-> !conv_clk_o && !first_channel_flag_o; endproperty
  a_sd_stop: assert property (p_sd_stop) else $error("clock runs in shutdown");
  property p_clk_run; on_w[*4] |-> conv_clk_o != $past(conv_clk_o); endproperty
  a_clk_run: assert property (p_clk_run) else $error("half cycle not advancing");
  // count of consecutive driven samples; twelve of them keep the whole pipeline live for one word
  logic [3:0] oe_run_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !result_bus_oe_o)
      oe_run_reg <= 4'h0;
    else if (oe_run_reg != 4'hf)
      oe_run_reg <= oe_run_reg + 4'h1;
  end
  // a first word was captured 11 edges back, a second word 12 edges back
  property p_code_top; result_bus_oe_o && first_channel_flag_o && oe_run_reg >= 4'hc
    && $past(first_channel_sample_i, 11) == 11'sh3ff |-> result_bus_o == 8'hff; endproperty
  a_code_top: assert property (p_code_top) else $error("top code wrong");
  property p_code_bot; result_bus_oe_o && !first_channel_flag_o && oe_run_reg >= 4'hc
    && $past(second_channel_sample_i, 12) == 11'sh400 |-> result_bus_o == 8'h00; endproperty
  a_code_bot: assert property (p_code_bot) else $error("bottom code wrong");
endmodule

// ===== tb.sv
// testbench for the converter port with a capture-side model
// assumes a 10 MHz clock and a synchronous active-high reset
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hi = 1'b0;
  logic lo = 1'b0;
  logic signed [dual_adc_pkg::IN_W-1:0] fs = '0;
  logic signed [dual_adc_pkg::IN_W-1:0] ss = '0;
  logic [7:0] bus_o, pa, pb;
  logic oe_o, flag_o, cclk_o;
  wire [7:0] bus_w = oe_o ? bus_o : 8'hzz;
  int bad_count = 0;
  int n_compared = 0;
  always #50 clk_i = ~clk_i;
  dual_adc_output_port dual_adc_output_port_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pwr_sel_hi_i(hi),
    .pwr_sel_lo_i(lo), .first_channel_sample_i(fs), .second_channel_sample_i(ss), .result_bus_o(bus_o),
    .result_bus_oe_o(oe_o), .first_channel_flag_o(flag_o), .conv_clk_o(cclk_o));
  capture_model capture_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .oe_i(oe_o), .flag_i(flag_o),
    .bus_i(bus_w), .pair_first_o(pa), .pair_second_o(pb));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic sel(input logic [1:0] m);
    @(posedge clk_i);
    {hi, lo} <= m;
  endtask
  task automatic t_modes();
    logic c;
    for (int m = 0; m < 4; m++)
    begin
      sel(m[1:0]);
      tick(4);
      c = cclk_o;
      tick(1);
      check(16'(oe_o), 16'(m == 3));
      check(16'(cclk_o ^ c), 16'(m != 0));
    end
  endtask
  task automatic t_wake();
    sel(2'b00);
    tick(3);
    check(16'(bus_w), 16'(8'hzz));
    sel(2'b11);
    tick(1);
    check(16'(oe_o), 16'h0000);
    tick(2);
    check(16'(oe_o), 16'h0001);
  endtask
  task automatic t_stream();
    tick(14);
    check(16'(bus_o), 16'h0080);
    do tick(1); while (cclk_o !== 1'b1);
    // change one edge after a capture edge so the next capture takes it
    @(posedge clk_i);
    fs <= 11'sh3ff;
    ss <= 11'sh400;
    tick(10);
    check(16'({flag_o, bus_o}), 16'h0080);
    tick(1);
    check(16'({flag_o, bus_o}), 16'h01ff);
    tick(1);
    check(16'({flag_o, bus_o}), 16'h0000);
    tick(1);
    check(16'(pa), 16'h00ff);
    check(16'(pb), 16'h0000);
    tick(6);
  endtask
  // idle ({hi,lo}=01) keeps converting behind a released bus; standby ({hi,lo}=10) clears the pipeline
  task automatic t_idle_standby();
    sel(2'b01);
    tick(14);
    do tick(1); while (flag_o !== 1'b1);
    check(16'({oe_o, bus_o}), 16'h00ff);
    sel(2'b10);
    tick(14);
    check(16'({oe_o, bus_o}), 16'h0080);
    sel(2'b11);
    tick(3);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    check(16'({bus_o, oe_o, flag_o, cclk_o}), 16'h0000);
    t_modes();
    t_wake();
    t_stream();
    t_idle_standby();
    stop_test();
  end
  initial
  begin
    #50000;
    bad_count++;
    stop_test();
  end
endmodule
bind dual_adc_output_port dual_adc_sva dual_adc_sva_i (.clk_i, .sys_rst_i, .pwr_sel_hi_i, .pwr_sel_lo_i,
  .first_channel_sample_i, .second_channel_sample_i, .result_bus_o, .result_bus_oe_o, .first_channel_flag_o,
  .conv_clk_o);
